// ==== common/ctrl_status_defines.svh ====
// Register offsets, field positions, reset values and timing counts of the control and status bank.
//----------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------
// Summary of operation
// - Writing one to bit 29 resets the whole controller except configuration space.
// - Bit 29 reads 0b normally, 1b requests reset, and hardware clears it.
// - Whole reset request sets the reset-asserted cause bit in the interrupt cause.
// - Whole reset acts only when the nonvolatile permit bit is set.
// - Whole reset request sets the whole-reset-seen status bit.
// - With bit 30 set, the receive path strips VLAN tags from 802.1Q frames.
// - Bit 31 holds the internal PHY in reset while one.
// - Status register sits at byte offset 0x0008 and is read-only.
// - Status bit 0 shows duplex: 0b half, 1b full.
// - Duplex bit shows the MAC's actual duplex configuration.
// - Status bit 1 shows link up from the internal PHY link indication.
// - Link-up bit is meaningful only in internal PHY mode.
// - Status bit 4 sets when transmit pauses on a received XOFF frame.
// - Status bit 4 clears on pause timer expiry or received XON.
// - Status bits 3:2 and 5 are reserved; written zero, read as zero.
// - PHY-reset-seen bit sets on PHY reset; software clears it writing zero.
`ifndef CTRL_STATUS_DEFINES_SVH
`define CTRL_STATUS_DEFINES_SVH

`define ADDR_W           16
`define OFS_CONTROL      16'h0000
`define OFS_STATUS       16'h0008
`define OFS_CAUSE        16'h00C0
`define OFS_SEEN         16'h0010

`define BIT_WHOLE_RST    29
`define BIT_VLAN_STRIP   30
`define BIT_PHY_RESET_REQUEST      31
`define BIT_FORCE_LINK   6

`define BIT_DUPLEX       0
`define BIT_LINK         1
`define BIT_TX_PAUSED    4
`define BIT_WHOLE_SEEN   19
`define BIT_PHY_SEEN     10

`define BIT_CAUSE_RESET  8

`define CONTROL_RESET    32'h0000_0000
`define PHY_SEEN_RESET   1'b1

`define WHOLE_RST_NS     64
`define CLOCK_NS         8
`define WHOLE_RST_CYCLES ((`WHOLE_RST_NS + `CLOCK_NS - 1) / `CLOCK_NS)

`endif

// ==== common/ctrl_status_pkg.sv ====
// Types shared by the control and status bank.
package ctrl_status_pkg;

	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		logic duplex_full;
		logic link_up;
		logic pause_on_xoff;
		logic resume_on_xon;
		logic pause_expired;
		logic flow_sym_negotiated;
		logic internal_phy_mode;
	} mac_state_t;

	typedef enum logic [1:0] {
		RST_IDLE  = 2'b01,
		RST_PULSE = 2'b10
	} whole_rst_state_t;

	typedef struct packed {
		logic [31:0]      control;
		logic             tx_paused;
		logic             whole_seen;
		logic             phy_seen;
		logic             cause_reset;
		logic [31:0]      rdata;
		whole_rst_state_t rst_state;
		logic [3:0]       rst_count;
	} bank_state_t;

endpackage

// ==== logic/device_control_status_bits.sv ====
// Control word upper bits, device status register and their side effects.
`timescale 1ns/10ps
`default_nettype none
`include "ctrl_status_defines.svh"

module device_control_status_bits (
	input  wire logic                        clock,          // Core clock, 125 MHz.
	input  wire logic                        rst,            // Asynchronous reset, active high.
	input  wire ctrl_status_pkg::reg_req_t   req,            // Register access request.
	output logic [31:0]                      rdata,          // Read data, one cycle after read.
	input  wire ctrl_status_pkg::mac_state_t mac,            // MAC, PHY and pause state.
	input  wire logic                        whole_reset_permit, // Nonvolatile permit bit.
	output logic                             whole_component_reset, // Reset pulse to the whole device.
	output logic                             vlan_strip_enable, // Receive path tag removal.
	output logic                             phy_reset_request, // Internal PHY held in reset.
	output logic                             force_link_up,  // Forced link-up control.
	output logic                             reset_asserted_cause // Cause bit to interrupt logic.
);

	ctrl_status_pkg::bank_state_t state;
	ctrl_status_pkg::bank_state_t next_state;

	//----------------------------------------------------------------------
	// Request decode
	//----------------------------------------------------------------------
	logic        wr_control;
	logic        wr_seen;
	logic        wr_cause;
	logic        rd_control;
	logic        rd_status;
	logic        rd_seen;
	logic        rd_cause;

	// The status register has no write decode, so a write to its offset 0x0008 changes none of its bits.
	assign wr_control = req.wr && (req.addr == `OFS_CONTROL);
	assign wr_seen    = req.wr && (req.addr == `OFS_SEEN);
	assign wr_cause   = req.wr && (req.addr == `OFS_CAUSE);
	assign rd_control = req.rd && (req.addr == `OFS_CONTROL);
	assign rd_status  = req.rd && (req.addr == `OFS_STATUS);
	assign rd_seen    = req.rd && (req.addr == `OFS_SEEN);
	assign rd_cause   = req.rd && (req.addr == `OFS_CAUSE);

	//----------------------------------------------------------------------
	// Event qualifiers
	//----------------------------------------------------------------------
	logic        whole_req;
	logic        whole_go;
	logic        in_pulse;
	logic        pulse_done;
	logic        cause_clear;
	logic        seen_clear;
	logic        pause_clear;
	logic        pause_set;

	// A request without permit is still recorded as a cause and as seen.
	assign whole_req   = wr_control && req.wdata[`BIT_WHOLE_RST];
	assign whole_go    = whole_req && whole_reset_permit;
	assign in_pulse    = (state.rst_state == ctrl_status_pkg::RST_PULSE);
	assign pulse_done  = (state.rst_count == 4'h0);
	assign cause_clear = rd_cause || (wr_cause && req.wdata[`BIT_CAUSE_RESET]);
	assign seen_clear  = wr_seen && !req.wdata[`BIT_PHY_SEEN];
	// A pause only means something while symmetric flow control is negotiated.
	assign pause_clear = !mac.flow_sym_negotiated || mac.pause_expired || mac.resume_on_xon;
	assign pause_set   = mac.pause_on_xoff;

	//----------------------------------------------------------------------
	// Read views
	//----------------------------------------------------------------------
	logic        link_shown;
	logic [31:0] status_view;
	logic [31:0] seen_view;
	logic [31:0] cause_view;
	logic [31:0] read_view;

	// Outside internal PHY mode the link indication is undefined, so it reads zero.
	assign link_shown = mac.link_up && mac.internal_phy_mode;

	// Reserved bits 3:2 and 5, and every bit not listed, read zero.
	assign status_view = (32'(mac.duplex_full) << `BIT_DUPLEX)
	                   | (32'(link_shown) << `BIT_LINK)
	                   | (32'(state.tx_paused) << `BIT_TX_PAUSED)
	                   | (32'(state.phy_seen) << `BIT_PHY_SEEN)
	                   | (32'(state.whole_seen) << `BIT_WHOLE_SEEN);
	assign seen_view   = 32'(state.phy_seen) << `BIT_PHY_SEEN;
	assign cause_view  = 32'(state.cause_reset) << `BIT_CAUSE_RESET;

	// Unmapped addresses and idle cycles select nothing and read zero.
	assign read_view = ({32{rd_control}} & state.control)
	                 | ({32{rd_status}} & status_view)
	                 | ({32{rd_seen}} & seen_view)
	                 | ({32{rd_cause}} & cause_view);

	//----------------------------------------------------------------------
	// Next-state logic
	//----------------------------------------------------------------------
	always_comb begin
		next_state = state;

		// The reset request bit is never stored, so it reads zero at once.
		if (wr_control) begin
			next_state.control                 = req.wdata;
			next_state.control[`BIT_WHOLE_RST] = 1'b0;
		end

		unique case (state.rst_state)
			ctrl_status_pkg::RST_IDLE: begin
				if (whole_go) begin
					next_state.rst_state = ctrl_status_pkg::RST_PULSE;
					next_state.rst_count = 4'(`WHOLE_RST_CYCLES - 1);
				end
			end
			ctrl_status_pkg::RST_PULSE: begin
				if (pulse_done) begin
					next_state.rst_state = ctrl_status_pkg::RST_IDLE;
				end else begin
					next_state.rst_count = state.rst_count - 4'h1;
				end
			end
			default: begin
				next_state.rst_state = ctrl_status_pkg::RST_IDLE;
			end
		endcase

		// While the device reset stands, control returns to its power-up value.
		if (in_pulse) begin
			next_state.control = `CONTROL_RESET;
		end

		// The cause bit clears on a read or a write of one; a new request wins.
		if (cause_clear) begin
			next_state.cause_reset = 1'b0;
		end
		if (whole_req) begin
			next_state.cause_reset = 1'b1;
		end

		// The seen bit clears on a write of zero; an active PHY reset wins.
		if (seen_clear) begin
			next_state.phy_seen = 1'b0;
		end
		if (next_state.control[`BIT_PHY_RESET_REQUEST]) begin
			next_state.phy_seen = 1'b1;
		end

		if (whole_req) begin
			next_state.whole_seen = 1'b1;
		end

		// Clear events win over a new XOFF; the device reset also ends a pause.
		if (pause_clear || in_pulse) begin
			next_state.tx_paused = 1'b0;
		end else if (pause_set) begin
			next_state.tx_paused = 1'b1;
		end

		next_state.rdata = read_view;
	end

	//----------------------------------------------------------------------
	// State register
	//----------------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state.control     <= `CONTROL_RESET;
			state.tx_paused   <= 1'b0;
			state.whole_seen  <= 1'b0;
			state.phy_seen    <= `PHY_SEEN_RESET;
			state.cause_reset <= 1'b0;
			state.rdata       <= 32'h0000_0000;
			state.rst_state   <= ctrl_status_pkg::RST_IDLE;
			state.rst_count   <= 4'h0;
		end else begin
			state <= next_state;
		end
	end

	//----------------------------------------------------------------------
	// Outputs
	//----------------------------------------------------------------------
	assign rdata                 = state.rdata;
	assign whole_component_reset = (state.rst_state == ctrl_status_pkg::RST_PULSE);
	assign vlan_strip_enable     = state.control[`BIT_VLAN_STRIP];
	assign phy_reset_request     = state.control[`BIT_PHY_RESET_REQUEST];
	assign force_link_up         = state.control[`BIT_FORCE_LINK];
	assign reset_asserted_cause  = state.cause_reset;

endmodule
`default_nettype wire

// ==== dv/ctrl_status_chk.sv ====
// Port assertions of the control and status bank.
`timescale 1ns/10ps
`default_nettype none
module ctrl_status_chk (
	input wire logic                        clock, // Clock.
	input wire logic                        rst, // Reset.
	input wire ctrl_status_pkg::reg_req_t   req, // Request.
	input wire logic [31:0]                 rdata, // Read data.
	input wire ctrl_status_pkg::mac_state_t mac, // MAC state.
	input wire logic                        whole_reset_permit, // Permit.
	input wire logic                        whole_component_reset, // Pulse.
	input wire logic                        vlan_strip_enable, // Strip.
	input wire logic                        phy_reset_request, // PHY reset.
	input wire logic                        reset_asserted_cause // Cause.
);
	logic wc;
	logic rs;
	assign wc = req.wr && req.addr == 16'h0000;
	assign rs = req.rd && req.addr == 16'h0008;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	property p_len; $rose(whole_component_reset) |-> whole_component_reset[*8] ##1 !whole_component_reset; endproperty
	a_len: assert property (p_len) else $error("pulse length");
	property p_go; wc && req.wdata[29] && whole_reset_permit |=> whole_component_reset; endproperty
	a_go: assert property (p_go) else $error("no reset pulse");
	property p_no; wc && req.wdata[29] && !whole_reset_permit && !whole_component_reset |=> !whole_component_reset; endproperty
	a_no: assert property (p_no) else $error("reset without permit");
	property p_cause; wc && req.wdata[29] |=> reset_asserted_cause; endproperty
	a_cause: assert property (p_cause) else $error("cause not set");
	property p_vlan; wc && !req.wdata[29] |=> vlan_strip_enable == $past(req.wdata[30]); endproperty
	a_vlan: assert property (p_vlan) else $error("strip bit");
	property p_phy; wc && !req.wdata[29] |=> phy_reset_request == $past(req.wdata[31]); endproperty
	a_phy: assert property (p_phy) else $error("phy reset bit");
	property p_fd; rs |=> rdata[0] == $past(mac.duplex_full) && rdata[3:2] == 2'h0 && !rdata[5]; endproperty
	a_fd: assert property (p_fd) else $error("duplex or reserved");
	property p_lu; rs && !mac.internal_phy_mode |=> !rdata[1]; endproperty
	a_lu: assert property (p_lu) else $error("link outside mode");
	c_pulse: cover property ($rose(whole_component_reset));
	c_stat: cover property (rs);
	c_cause: cover property (reset_asserted_cause);
endmodule
bind device_control_status_bits ctrl_status_chk ctrl_status_chk_i (.clock(clock), .rst(rst), .req(req),
	.rdata(rdata), .mac(mac), .whole_reset_permit(whole_reset_permit),
	.whole_component_reset(whole_component_reset), .vlan_strip_enable(vlan_strip_enable),
	.phy_reset_request(phy_reset_request), .reset_asserted_cause(reset_asserted_cause));
`default_nettype wire

// ==== dv/mac_model.sv ====
// Model of the MAC, PHY link and pause event sources.
`timescale 1ns/10ps
`default_nettype none
module mac_model (
	input wire logic                        clock, // Core clock.
	output var ctrl_status_pkg::mac_state_t mac // State seen by the bank.
);
	initial mac = '0;
	// Negotiated levels change after an edge and then stand.
	task automatic lv(input logic [6:0] v);
		@(posedge clock) mac <= v;
	endtask
	// One-cycle pause or resume event on field b.
	task automatic ev(input int b);
		@(posedge clock) mac[b] <= 1'b1;
		@(posedge clock) mac[b] <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench of the control and status bank.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic                        clock = 1'b0;
	logic                        rst = 1'b1;
	logic                        permit = 1'b1;
	ctrl_status_pkg::reg_req_t   req = '0;
	ctrl_status_pkg::mac_state_t mac;
	logic [31:0]                 rdata;
	logic                        wcr, vse, prr, flu, rac;
	int                          error_cnt = 0;
	int                          checked = 0;
	int                          n;
	always #4 clock = ~clock;
	mac_model mac_model_i (.clock(clock), .mac(mac));
	device_control_status_bits device_control_status_bits_i (.clock(clock), .rst(rst), .req(req),
		.rdata(rdata), .mac(mac), .whole_reset_permit(permit), .whole_component_reset(wcr),
		.vlan_strip_enable(vse), .phy_reset_request(prr), .force_link_up(flu), .reset_asserted_cause(rac));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clock);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clock);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		@(posedge clock);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clock);
		req.rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task automatic stop_test;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#20000;
		error_cnt++;
		stop_test();
	end
	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		rd(16'h0000, 32'h0000_0000);
		rd(16'h0008, 32'h0000_0400);
		rd(16'h0010, 32'h0000_0400);
		wr(16'h0000, 32'h0000_0040);
		mac_model_i.lv(7'h63);
		wr(16'h0008, 32'hFFFF_FFFF);
		rd(16'h0008, 32'h0000_0403);
		mac_model_i.lv(7'h62);
		rd(16'h0008, 32'h0000_0401);
		mac_model_i.ev(4);
		rd(16'h0008, 32'h0000_0411);
		mac_model_i.ev(3);
		rd(16'h0008, 32'h0000_0401);
		mac_model_i.ev(4);
		rd(16'h0008, 32'h0000_0411);
		mac_model_i.ev(2);
		rd(16'h0008, 32'h0000_0401);
		mac_model_i.lv(7'h20);
		mac_model_i.ev(4);
		rd(16'h0008, 32'h0000_0400);
		wr(16'h0000, 32'hC000_0040);
		#1 chk({29'h0, vse, prr, flu}, 32'h0000_0007);
		wr(16'h0010, 32'h0000_0000);
		rd(16'h0010, 32'h0000_0400);
		wr(16'h0000, 32'h0000_0040);
		wr(16'h0010, 32'h0000_0000);
		rd(16'h0010, 32'h0000_0000);
		wr(16'h0000, 32'h2000_0040);
		n = 0;
		repeat (12) begin
			#1 n += wcr;
			@(posedge clock);
		end
		chk(n, 32'h0000_0008);
		chk({31'h0, rac}, 32'h0000_0001);
		rd(16'h00C0, 32'h0000_0100);
		chk({31'h0, rac}, 32'h0000_0000);
		rd(16'h0000, 32'h0000_0000);
		rd(16'h0008, 32'h0008_0000);
		@(posedge clock) permit <= 1'b0;
		wr(16'h0000, 32'h2000_0040);
		#1 chk({30'h0, wcr, rac}, 32'h0000_0001);
		rd(16'h0000, 32'h0000_0040);
		wr(16'h00C0, 32'h0000_0100);
		#1 chk({31'h0, rac}, 32'h0000_0000);
		stop_test();
	end
endmodule
`default_nettype wire
